// ### cmd_port_consts.svh
// Constants for the readout configuration command port
// Behaviour
// [R1] Network source address bits 14..0 come from source register bits 14..0; also serial number.
// [R2] Upper 16 address bits are a fixed firmware constant, not writable.
// [R3] Source register bit 15 rising edge applies the new address value.
// [R4] Commands are twelve fixed bytes; the length field is ignored.
// [R5] Status, system reset and config write reply; fast pointer reset does not.
// [R6] Register number and value are used only by config write commands.
// [R7] Reply holds code, spare, length, then all 32 status words in order.
// [R8] Host reads each reply before sending its next command.
// [R9] System reset command requests full reset, then input auto-sense.
// [R10] Fast reset clears only buffer pointers, keeping buffer contents.
// [R11] Host waits 10 ms after fast reset before enabling triggers.
// [R12] Host writes select and count, then same word with bit 3 set.
// [R13] Six buffers, two channels each, read out one at a time.
// [R14] Host limits row count to what its receivers can absorb.
// [R15] Host inhibits triggers before requesting transmission.
// [R16] Each frame carries exactly one 1024-byte memory row.
// [R17] Remainder zero means last frame empty; nonzero means some valid data.
// [R18] Green: always on, both clock managers locked, global ready.
// [R19] Yellow: level-0 trigger pulse, any buffer writing, any buffer reading.
// [R20] Red: unmasked loss of sync, timing receiver not ready, ack error.
// [R21] Microcontroller loads a unique source address at its reset.
// [R22] Host writes start row before each transfer and repeats until done.
// [R23] Transfer starts only on rising edge of read control bit 3.
// [R24] Rows sent equal the written row count plus one.
// [R25] Remainder counts valid 32-bit words, kept per controller group.
// [R26] Unknown command codes are ignored without reply.
`ifndef CMD_PORT_CONSTS_SVH
`define CMD_PORT_CONSTS_SVH

`define CMD_STATUS_QUERY     8'h01
`define CMD_SYSTEM_RESET     8'h02
`define CMD_CONFIG_WRITE     8'h03
`define CMD_FAST_PTR_RESET   8'h04
`define REPLY_STATUS_CODE    8'h01
`define CMD_LAST_BYTE        4'h0b
`define CMD_IDX_CODE         4'h0
`define CMD_IDX_REGNUM       4'h8
`define CMD_IDX_VAL_LO       4'ha
`define CMD_IDX_VAL_HI       4'hb
`define RSP_LENGTH           16'h0040
`define RSP_LAST_BYTE        7'h43
`define STATUS_WORDS         32
`define STATUS_REMAINDER     5'h04
`define CREG_READ_CTRL       8'h00
`define CREG_READ_START      8'h01
`define CREG_CHAN_FIRST      8'h10
`define CREG_CHAN_LAST       8'h1b
`define CREG_SRC_ADDR        8'h1f
`define RDCTL_TRIG_BIT       3
`define RDCTL_SEL_LSB        0
`define RDCTL_CNT_LSB        8
`define CHAN_INHIBIT_BIT     1
`define SRC_UPDATE_BIT       15
`define NUM_BUFFERS          3'h6
`define NUM_CHANNELS         12
`define FRAME_ROW_BYTES      11'h400
`define CLK_PERIOD_NS        10
`define LED_PULSE_NS         10000
`define LED_PULSE_CYC        ((`LED_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### cmd_port_pkg.sv
// Types for the readout configuration command port
package cmd_port_pkg;
  typedef enum logic [2:0] {
    ST_RECV  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_REPLY = 3'b100
  } cp_state_t;
endpackage

// ### reply_fifo.sv
// Small synchronous FIFO for reply bytes
`timescale 1ns/100ps
module reply_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  wire              push;
  wire              pop;

  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ### readout_config_command_port.sv
// Command interpreter, readout sequencer and indicators of the buffer module
`timescale 1ns/100ps
`include "cmd_port_consts.svh"
module readout_config_command_port
  import cmd_port_pkg::*;
#(
  parameter int          FIFO_DEPTH    = 8,
  parameter logic [15:0] NET_ADDR_HIGH = 16'h0000  // Arbitrary value
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [7:0]   cmd_byte,
  input  wire logic         cmd_valid,
  output logic              cmd_ready,
  output logic [7:0]        rsp_byte,
  output logic              rsp_valid,
  input  wire logic         rsp_ready,
  input  wire logic [511:0] status_words,
  input  wire logic [7:0]   rem_grp0,
  input  wire logic [7:0]   rem_grp1,
  output logic              cfg_wr,
  output logic [7:0]        cfg_reg_num,
  output logic [15:0]       cfg_value,
  output logic              sys_reset_req,
  output logic              autosense_req,
  output logic              fast_ptr_reset,
  output logic [31:0]       net_src_addr,
  output logic [14:0]       serial_number,
  output logic              row_req,
  input  wire logic         row_ack,
  output logic [2:0]        row_mem_sel,
  output logic [14:0]       row_addr,
  output logic [10:0]       row_bytes,
  input  wire logic         dcm_top_locked,
  input  wire logic         dcm_bot_locked,
  input  wire logic         global_ready,
  input  wire logic         l0_trigger,
  input  wire logic [5:0]   buf_writing,
  input  wire logic [5:0]   buf_reading,
  input  wire logic [11:0]  chan_loss_sync,
  input  wire logic         timing_rx_ready,
  input  wire logic         timing_ack_err,
  output logic [2:0]        led_green,
  output logic [2:0]        led_yellow,
  output logic [2:0]        led_red
);
  localparam int LED_CYC = `LED_PULSE_CYC;

  cp_state_t    state_ff;
  cp_state_t    nxt_state;
  logic [3:0]   cmd_idx_ff;
  logic [7:0]   code_ff;
  logic [7:0]   regnum_ff;
  logic [15:0]  value_ff;
  logic [6:0]   rsp_idx_ff;
  logic [15:0]  rdctl_ff;
  logic [14:0]  rdstart_ff;
  logic [15:0]  srcreg_ff;
  logic [14:0]  src_low_ff;
  logic [11:0]  inhibit_ff;
  logic [8:0]   rows_left_ff;
  logic [16:0]  sync1_ff;
  logic [16:0]  sync2_ff;
  logic [15:0]  led_cnt_ff;

  // Command byte intake and decode
  wire        cmd_take  = cmd_valid & cmd_ready;
  wire        cmd_done  = cmd_take & (cmd_idx_ff == `CMD_LAST_BYTE);
  wire        is_stat   = (code_ff == `CMD_STATUS_QUERY);
  wire        is_rst    = (code_ff == `CMD_SYSTEM_RESET);
  wire        is_cfg    = (code_ff == `CMD_CONFIG_WRITE);
  wire        is_fast   = (code_ff == `CMD_FAST_PTR_RESET);
  wire        in_exec   = (state_ff == ST_EXEC);
  wire        needs_rsp = is_stat | is_rst | is_cfg;
  wire        cfg_now   = in_exec & is_cfg;
  wire        wr_rdctl  = cfg_now & (regnum_ff == `CREG_READ_CTRL);
  wire        wr_start  = cfg_now & (regnum_ff == `CREG_READ_START);
  wire        wr_src    = cfg_now & (regnum_ff == `CREG_SRC_ADDR);
  wire        wr_chan   = cfg_now & (regnum_ff >= `CREG_CHAN_FIRST)
                          & (regnum_ff <= `CREG_CHAN_LAST);
  wire [3:0]  chan_sel  = regnum_ff[3:0];
  wire        src_rise  = wr_src & ~srcreg_ff[`SRC_UPDATE_BIT] & value_ff[`SRC_UPDATE_BIT];
  wire [2:0]  req_sel   = value_ff[`RDCTL_SEL_LSB +: 3];
  wire        xfer_trig = wr_rdctl & ~rdctl_ff[`RDCTL_TRIG_BIT] & value_ff[`RDCTL_TRIG_BIT]
                          & (req_sel < `NUM_BUFFERS) & ~row_req;
  wire        row_take  = row_req & row_ack;

  // Reply byte selection
  wire        fifo_in_ready;
  wire        rsp_push  = (state_ff == ST_REPLY) & fifo_in_ready;
  wire [6:0]  body_idx  = rsp_idx_ff - 7'h04;
  wire [4:0]  word_sel  = body_idx[5:1];
  wire [15:0] stat_word = (word_sel == `STATUS_REMAINDER) ? {rem_grp1, rem_grp0}  // [R17] [R25]
                          : status_words[{word_sel, 4'h0} +: 16];
  wire [7:0]  body_byte = body_idx[0] ? stat_word[15:8] : stat_word[7:0];
  wire [15:0] rsp_len   = `RSP_LENGTH;
  wire [7:0]  rsp_data  = (rsp_idx_ff == 7'h00) ? `REPLY_STATUS_CODE
                        : (rsp_idx_ff == 7'h01) ? 8'h00
                        : (rsp_idx_ff == 7'h02) ? rsp_len[7:0]
                        : (rsp_idx_ff == 7'h03) ? rsp_len[15:8]
                        : body_byte;

  assign cmd_ready = (state_ff == ST_RECV);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RECV: begin
        if (cmd_done) begin
          nxt_state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        nxt_state = needs_rsp ? ST_REPLY : ST_RECV;  // [R5] [R26]
      end
      ST_REPLY: begin
        if (rsp_push && rsp_idx_ff == `RSP_LAST_BYTE) begin
          nxt_state = ST_RECV;
        end
      end
      default: begin
        nxt_state = ST_RECV;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_RECV;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Only code, register number and value bytes are kept; length is ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_idx_ff <= 4'h0;
      code_ff    <= 8'h00;
      regnum_ff  <= 8'h00;
      value_ff   <= 16'h0000;
    end else if (cmd_take) begin
      cmd_idx_ff <= cmd_done ? 4'h0 : cmd_idx_ff + 4'h1;  // [R4]
      if (cmd_idx_ff == `CMD_IDX_CODE) code_ff <= cmd_byte;
      if (cmd_idx_ff == `CMD_IDX_REGNUM) regnum_ff <= cmd_byte;
      if (cmd_idx_ff == `CMD_IDX_VAL_LO) value_ff[7:0] <= cmd_byte;
      if (cmd_idx_ff == `CMD_IDX_VAL_HI) value_ff[15:8] <= cmd_byte;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_idx_ff <= 7'h00;
    end else if (state_ff != ST_REPLY) begin
      rsp_idx_ff <= 7'h00;
    end else if (rsp_push) begin
      rsp_idx_ff <= rsp_idx_ff + 7'h01;  // [R7]
    end
  end

  // Command side effects
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_wr         <= 1'b0;
      cfg_reg_num    <= 8'h00;
      cfg_value      <= 16'h0000;
      sys_reset_req  <= 1'b0;
      autosense_req  <= 1'b0;
      fast_ptr_reset <= 1'b0;
    end else begin
      cfg_wr         <= cfg_now;  // [R6]
      if (cfg_now) begin
        cfg_reg_num <= regnum_ff;
        cfg_value   <= value_ff;
      end
      sys_reset_req  <= in_exec & is_rst;  // [R9]
      autosense_req  <= sys_reset_req;  // [R9]
      fast_ptr_reset <= in_exec & is_fast;  // [R10]
    end
  end

  // Local copies of the control registers this block acts on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdctl_ff   <= 16'h0000;
      rdstart_ff <= 15'h0000;
      srcreg_ff  <= 16'h0000;
      src_low_ff <= 15'h0000;
      inhibit_ff <= 12'h000;
    end else if (in_exec && is_rst) begin
      rdctl_ff   <= 16'h0000;
      rdstart_ff <= 15'h0000;
      srcreg_ff  <= 16'h0000;
      src_low_ff <= 15'h0000;
      inhibit_ff <= 12'h000;
    end else begin
      if (wr_rdctl) rdctl_ff <= value_ff;
      if (wr_start) rdstart_ff <= value_ff[14:0];
      if (wr_src) srcreg_ff <= value_ff;
      if (src_rise) src_low_ff <= value_ff[14:0];  // [R3]
      if (wr_chan) inhibit_ff[chan_sel] <= value_ff[`CHAN_INHIBIT_BIT];
    end
  end

  assign serial_number = src_low_ff;  // [R1]
  assign net_src_addr  = {NET_ADDR_HIGH, 1'b0, src_low_ff};  // [R1] [R2]

  // Row sequencer: one frame per row request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rows_left_ff <= 9'h000;
      row_addr     <= 15'h0000;
      row_mem_sel  <= 3'h0;
    end else if (in_exec && is_rst) begin
      rows_left_ff <= 9'h000;
    end else if (xfer_trig) begin
      rows_left_ff <= {1'b0, value_ff[`RDCTL_CNT_LSB +: 8]} + 9'h001;  // [R23] [R24]
      row_addr     <= rdstart_ff;
      row_mem_sel  <= req_sel;  // [R13]
    end else if (row_take) begin
      rows_left_ff <= rows_left_ff - 9'h001;
      row_addr     <= row_addr + 15'h0001;
    end
  end

  assign row_req   = (rows_left_ff != 9'h000);
  assign row_bytes = `FRAME_ROW_BYTES;  // [R16]

  // Indicators; asynchronous levels pass two flip-flops first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 17'h0_0000;
      sync2_ff <= 17'h0_0000;
    end else begin
      sync1_ff <= {dcm_top_locked, dcm_bot_locked, global_ready, timing_rx_ready,
                   timing_ack_err, chan_loss_sync};
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_cnt_ff <= 16'h0000;
      led_green  <= 3'h1;
      led_yellow <= 3'h0;
      led_red    <= 3'h0;
    end else begin
      led_cnt_ff <= l0_trigger ? 16'(LED_CYC) : (led_cnt_ff != 16'h0000) ?
                    led_cnt_ff - 16'h0001 : 16'h0000;
      led_green  <= {sync2_ff[14], sync2_ff[16] & sync2_ff[15], 1'b1};  // [R18]
      led_yellow <= {|buf_reading, |buf_writing, l0_trigger | (led_cnt_ff != 16'h0000)};  // [R19]
      led_red    <= {sync2_ff[12], ~sync2_ff[13], |(sync2_ff[11:0] & ~inhibit_ff)};  // [R20]
    end
  end

  reply_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_reply_fifo (
    .clk      (clk),
    .rst      (rst),
    .in_data  (rsp_data),
    .in_valid (state_ff == ST_REPLY),
    .in_ready (fifo_in_ready),
    .out_data (rsp_byte),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready)
  );

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence exec_fast_s;
    in_exec && is_fast;
  endsequence

  sequence exec_unknown_s;
    in_exec && !needs_rsp && !is_fast;
  endsequence

  sequence trig_write_s;
    xfer_trig;
  endsequence

  fast_no_reply_a: assert property (exec_fast_s |=> state_ff == ST_RECV && fast_ptr_reset)  // [R5]
    else $error("fast reset produced a reply");
  fast_ptr_only_a: assert property (exec_fast_s |=> !sys_reset_req && !cfg_wr)  // [R10]
    else $error("fast reset caused other effects");
  unknown_ignored_a: assert property (exec_unknown_s |=> state_ff == ST_RECV && !cfg_wr  // [R26]
                                      && !fast_ptr_reset && !sys_reset_req)
    else $error("unknown command acted on");
  reply_head_a: assert property (state_ff == ST_REPLY && rsp_idx_ff == 7'h00  // [R7]
                                 |-> rsp_data == `REPLY_STATUS_CODE)
    else $error("reply code wrong");
  reply_leaves_a: assert property (in_exec && needs_rsp |=> state_ff == ST_REPLY  // [R5]
                                   ##1 state_ff == ST_REPLY)
    else $error("reply not produced");
  reset_sense_a: assert property (in_exec && is_rst |=> sys_reset_req ##1 autosense_req)  // [R9]
    else $error("auto-sense not after reset");
  cfg_only_a: assert property (cfg_wr |-> $past(is_cfg) && cfg_value == $past(value_ff))  // [R6]
    else $error("config write from wrong command");
  src_update_a: assert property (src_rise |=> serial_number == $past(value_ff[14:0]))  // [R3]
    else $error("source address not applied");
  src_hold_a: assert property (!src_rise && !(in_exec && is_rst) |=> $stable(serial_number))  // [R3]
    else $error("source address changed without edge");
  addr_high_a: assert property (net_src_addr[31:16] == NET_ADDR_HIGH  // [R2]
                                && net_src_addr[14:0] == serial_number)
    else $error("source address layout wrong");
  rows_plus_a: assert property (trig_write_s |=> rows_left_ff  // [R24]
                                == {1'b0, $past(value_ff[15:8])} + 9'h001)
    else $error("row count not plus one");
  no_level_a: assert property (wr_rdctl && rdctl_ff[3] && !row_req |=> !row_req)  // [R23]
    else $error("transfer started on level");
  green_a: assert property (led_green[0]  // [R18]
                            && (led_green[1] == $past(sync2_ff[16] && sync2_ff[15])))
    else $error("green indicator wrong");
endmodule

// ### host_model.sv
// Host side model: drains reply bytes and takes data rows with random stalls
`timescale 1ns/100ps
module host_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rsp_valid,
  output logic             rsp_ready,
  input  wire logic        row_req,
  output logic             row_ack,
  input  wire logic [14:0] row_addr,
  output int               rows_taken,
  output logic [14:0]      last_row_addr
);
  // Stalls change just after the falling edge
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      rsp_ready <= 1'b0;
      row_ack   <= 1'b0;
    end else begin
      rsp_ready <= ($urandom % 3) != 0;
      row_ack   <= ($urandom % 4) != 0;
    end
  end
  // Counts rows taken and where the last one came from
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rows_taken    <= 0;
      last_row_addr <= '0;
    end else if (row_req && row_ack) begin
      rows_taken    <= rows_taken + 1;
      last_row_addr <= row_addr;
    end
  end
endmodule

// ### tb_top.sv
// Self-checking bench for the readout configuration command port
`timescale 1ns/100ps
`include "cmd_port_consts.svh"
module tb_top;
  localparam logic [15:0] ADDR_HIGH = 16'h5a3c;  // Arbitrary value
  logic         clk, rst, cmd_valid, cmd_ready, rsp_valid, rsp_ready, cfg_wr;
  logic         sys_reset_req, autosense_req, fast_ptr_reset, row_req, row_ack;
  logic         l0_trigger, dcm_top_locked, dcm_bot_locked, global_ready;
  logic         timing_rx_ready, timing_ack_err;
  logic [7:0]   cmd_byte, rsp_byte, rem_grp0, rem_grp1, cfg_reg_num, e;
  logic [511:0] status_words;
  logic [15:0]  cfg_value, w;
  logic [31:0]  net_src_addr;
  logic [14:0]  serial_number, row_addr, last_row_addr, start, sa;
  logic [2:0]   row_mem_sel, led_green, led_yellow, led_red, sel;
  logic [10:0]  row_bytes;
  logic [5:0]   buf_writing, buf_reading;
  logic [11:0]  chan_loss_sync;
  logic [7:0]   cnt, codes[5];
  logic [7:0]   exp_q[$];
  int           num_errors, check_count, n_cfg, n_sys, n_auto, n_fast, rows_taken;
  int           s0, a0, f0, c0, r0;

  readout_config_command_port #(.NET_ADDR_HIGH(ADDR_HIGH)) readout_config_command_port_i (
    .clk, .rst, .cmd_byte, .cmd_valid, .cmd_ready, .rsp_byte, .rsp_valid, .rsp_ready,
    .status_words, .rem_grp0, .rem_grp1, .cfg_wr, .cfg_reg_num, .cfg_value,
    .sys_reset_req, .autosense_req, .fast_ptr_reset, .net_src_addr, .serial_number,
    .row_req, .row_ack, .row_mem_sel, .row_addr, .row_bytes, .dcm_top_locked,
    .dcm_bot_locked, .global_ready, .l0_trigger, .buf_writing, .buf_reading,
    .chan_loss_sync, .timing_rx_ready, .timing_ack_err, .led_green, .led_yellow, .led_red);
  host_model host_model_i (
    .clk, .rst, .rsp_valid, .rsp_ready, .row_req, .row_ack, .row_addr, .rows_taken,
    .last_row_addr);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Sends one command, noting the expected reply bytes first
  task automatic send(input logic [7:0] code, input logic [7:0] rnum, input logic [15:0] val);
    logic [7:0] msg [12];
    int         n;
    msg = '{code, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, rnum, 8'h00, val[7:0],
            val[15:8]};
    for (int i = 0; i < 16; i++) status_words[32*i +: 32] = $urandom;
    {rem_grp1, rem_grp0} = 16'($urandom);
    if (code inside {`CMD_STATUS_QUERY, `CMD_SYSTEM_RESET, `CMD_CONFIG_WRITE}) begin
      exp_q.push_back(`REPLY_STATUS_CODE);
      exp_q.push_back(8'h00);
      exp_q.push_back(8'(2 * 32));
      exp_q.push_back(8'h00);
      for (int k = 0; k < 32; k++) begin
        w = (k == 4) ? {rem_grp1, rem_grp0} : status_words[16*k +: 16];
        exp_q.push_back(w[7:0]);
        exp_q.push_back(w[15:8]);
      end
    end
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      cmd_byte  = msg[i];
      cmd_valid = 1'b1;
      for (n = 0; cmd_ready !== 1'b1 && n < 200; n++) @(negedge clk);
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_byte  = 8'($urandom);
    for (n = 0; (exp_q.size() != 0 || cmd_ready !== 1'b1) && n < 800; n++) @(negedge clk);
    chk(exp_q.size() == 0 && cmd_ready === 1'b1, 1, "port idle");
    repeat (6) @(negedge clk);
  endtask

  // Reply watcher: takes the oldest note at each accepted byte
  always @(posedge clk) begin
    n_cfg  += (cfg_wr === 1'b1);
    n_sys  += (sys_reset_req === 1'b1);
    n_auto += (autosense_req === 1'b1);
    n_fast += (fast_ptr_reset === 1'b1);
    if (rst === 1'b0 && rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      check_count++;
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("[ERR] %0t unexpected reply byte %h", $time, rsp_byte);
      end else begin
        e = exp_q.pop_front();
        if (rsp_byte !== e) begin
          num_errors++;
          $display("[ERR] %0t reply byte %h exp %h", $time, rsp_byte, e);
        end
      end
    end
  end

  initial begin
    #300_000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    void'($urandom(74));
    {rst, cmd_valid, cmd_byte, l0_trigger, buf_writing, buf_reading, chan_loss_sync} = '1;
    {cmd_valid, l0_trigger, buf_writing, buf_reading, chan_loss_sync} = '0;
    {dcm_top_locked, dcm_bot_locked, global_ready, timing_ack_err} = '0;
    {timing_rx_ready, cmd_byte, status_words, rem_grp0, rem_grp1} = '0;
    timing_rx_ready = 1'b1;
    @(negedge clk);
    chk(led_green, 3'b001, "reset green");
    chk(net_src_addr, {ADDR_HIGH, 16'h0000}, "reset address");
    @(negedge clk);
    rst = 1'b0;
    codes = '{`CMD_STATUS_QUERY, `CMD_SYSTEM_RESET, `CMD_FAST_PTR_RESET, 8'h07, 8'h00};
    foreach (codes[i]) begin
      {s0, a0, f0, c0} = {n_sys, n_auto, n_fast, n_cfg};
      send(codes[i], 8'h01, 16'hffff);
      chk(n_sys - s0, codes[i] == `CMD_SYSTEM_RESET, "reset pulse");
      chk(n_auto - a0, codes[i] == `CMD_SYSTEM_RESET, "autosense pulse");
      chk(n_fast - f0, codes[i] == `CMD_FAST_PTR_RESET, "fast pulse");
      chk(n_cfg - c0, 0, "config pulse");
    end
    $display("test command codes done");
    sa = 15'($urandom);
    c0 = n_cfg;
    send(`CMD_CONFIG_WRITE, 8'h1f, {1'b0, sa});
    chk(net_src_addr, {ADDR_HIGH, 16'h0000}, "address held");
    send(`CMD_CONFIG_WRITE, 8'h1f, {1'b1, sa});
    chk(net_src_addr, {ADDR_HIGH, 1'b0, sa}, "address applied");
    chk(serial_number, sa, "serial");
    chk({cfg_reg_num, cfg_value}, {8'h1f, 1'b1, sa}, "config fields");
    chk(n_cfg - c0, 2, "config pulses");
    send(`CMD_CONFIG_WRITE, 8'h1f, {1'b0, ~sa});
    chk(net_src_addr, {ADDR_HIGH, 1'b0, sa}, "falling bit held");
    $display("test source address done");
    for (int t = 0; t < 2; t++) begin
      sel   = t ? 3'd5 : 3'd2;
      cnt   = t ? 8'd0 : 8'd9;
      start = t ? 15'($urandom % 1000) : 15'h0;
      r0    = rows_taken;
      send(`CMD_CONFIG_WRITE, 8'h01, {1'b0, start});
      send(`CMD_CONFIG_WRITE, 8'h00, {cnt, 5'h00, sel});
      chk(rows_taken - r0, 0, "no rows before trigger");
      send(`CMD_CONFIG_WRITE, 8'h00, {cnt, 5'h01, sel});
      for (int n = 0; row_req !== 1'b0 && n < 200; n++) @(negedge clk);
      chk(rows_taken - r0, cnt + 1, "row count");
      chk(last_row_addr, start + cnt, "last row");
      chk(row_mem_sel, sel, "memory select");
      chk(row_bytes, 11'd1024, "frame bytes");
      send(`CMD_CONFIG_WRITE, 8'h00, {cnt, 5'h01, sel});
      chk(rows_taken - r0, cnt + 1, "level gives no rows");
    end
    r0 = rows_taken;
    send(`CMD_CONFIG_WRITE, 8'h00, 16'h0106);
    send(`CMD_CONFIG_WRITE, 8'h00, 16'h010e);
    chk(rows_taken - r0, 0, "select six refused");
    $display("test readout done");
    send(`CMD_CONFIG_WRITE, 8'h13, 16'h0002);
    chk(led_yellow[0], 1'b0, "trigger light idle");
    l0_trigger = 1'b1;
    @(negedge clk);
    l0_trigger = 1'b0;
    repeat (5) @(negedge clk);
    chk(led_yellow[0], 1'b1, "trigger light");
    repeat (1010) @(negedge clk);
    chk(led_yellow[0], 1'b0, "trigger light ends");
    for (int k = 0; k < 4; k++) begin
      {dcm_top_locked, dcm_bot_locked, global_ready, timing_rx_ready, timing_ack_err} =
        5'($urandom);
      buf_writing    = 6'($urandom) & {6{k[0]}};
      buf_reading    = 6'($urandom) & {6{k[1]}};
      chan_loss_sync = k[0] ? 12'h008 : 12'($urandom);
      repeat (5) @(negedge clk);
      chk(led_green, {global_ready, dcm_top_locked & dcm_bot_locked, 1'b1}, "green");
      chk(led_yellow[2:1], {|buf_reading, |buf_writing}, "yellow");
      chk(led_red, {timing_ack_err, ~timing_rx_ready, |(chan_loss_sync & ~12'h008)},
          "red");
    end
    $display("test indicators done");
    conclude();
  end
endmodule
